// [hw/wdrc_pkg.sv]
package wdrc_pkg;
    localparam logic [7:0] WDRC_ADDR_CTRL = 8'h7f;
    localparam int WDRC_DATA_W = 4;
    localparam int WDRC_CNT_W = 3;
    localparam int WDRC_CLR_BIT = 3;
    localparam logic [2:0] WDRC_CNT_RST = 3'h0;
    localparam int WDRC_SYS_CLK_HZ = 40000000;
    localparam int WDRC_TICK_HZ = 2;
    localparam int WDRC_RESET_PULSE_CYC = 4;
    typedef enum logic [1:0] {
        WDRC_ST_RUN = 2'b00,
        WDRC_ST_FIRE = 2'b01
    } wdrc_state_t;
endpackage

// [hw/wdrc_bus_if.sv]
`timescale 1ns/1ps
interface wdrc_bus_if;
    logic wr;
    logic [3:0] wdata;
    logic clr;
    modport dec (input wr, input wdata, output clr);
    modport core (input clr);
endinterface

// [hw/wdrc_tick_sync.sv]
`timescale 1ns/1ps
module wdrc_tick_sync (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic tick_i,
    output logic rise_o
);
    logic s1;
    logic s2;
    logic s3;
    logic next_s1;
    logic next_s2;
    logic next_s3;
    always_comb begin
        next_s1 = tick_i;
        next_s2 = s1;
        next_s3 = s2;
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
        end
    end
    // Edge taken after the second stage only
    assign rise_o = s2 & ~s3;
endmodule // wdrc_tick_sync

// [hw/wdrc_watchdog.sv]
// Functional notes
// - Counter advances only on the slow 2 Hz timer tick.
// - Three-bit counter; top bit overflow raises the watchdog reset.
// - Reset issued when uncleared for three and a half to four seconds.
// - Counting continues during processor halt; halt cannot block reset.
// - Writing 1 to clear bit zeroes counter; counting resumes at once.
// - Writing 0 does nothing; clear bit always reads 0.
// - Count bits read-only in bits 2..0, zero after reset.
// - Build option masks the overflow only; counter still counts and reads, no reset generated.
`timescale 1ns/1ps
module wdrc_watchdog
    import wdrc_pkg::*;
#(
    parameter bit WDOG_PRESENT = 1'b1,
    parameter int RESET_PULSE_CYC = WDRC_RESET_PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic tick_2hz_i,
    input wire logic halt_i,
    input wire logic init_reset_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [3:0] io_wdata_i,
    output logic [3:0] io_rdata_o,
    output logic wdog_reset_o
);
    wdrc_bus_if bus ();
    logic tick;
    logic clr_req;
    logic init_req;
    logic overflow;
    logic fire_done;
    logic [WDRC_CNT_W-1:0] count;
    logic [WDRC_CNT_W-1:0] next_count;
    wdrc_state_t state;
    wdrc_state_t next_state;
    logic [7:0] pulse_cnt;
    logic [7:0] next_pulse_cnt;
    logic wdog_reset;
    logic next_wdog_reset;
    logic [3:0] rdata;
    logic [3:0] next_rdata;
    logic unused_halt;

    function automatic logic hit(input logic [7:0] a);
        return a == WDRC_ADDR_CTRL;
    endfunction

    function automatic logic at_top(input logic [WDRC_CNT_W-1:0] c);
        return c == {WDRC_CNT_W{1'b1}};
    endfunction

    function automatic logic [WDRC_CNT_W-1:0] step(input logic [WDRC_CNT_W-1:0] c);
        return c + WDRC_CNT_W'(1);
    endfunction

    wdrc_tick_sync u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(tick_2hz_i),
        .rise_o(tick)
    );

    // Clear strobe decode; count bits are never written
    assign bus.wr = io_wr_i & hit(io_addr_i);
    assign bus.wdata = io_wdata_i;
    assign bus.clr = bus.wr & bus.wdata[WDRC_CLR_BIT];
    assign clr_req = bus.clr;
    assign init_req = init_reset_i;

    // Clear and initial reset both beat a tick on the same cycle
    assign overflow = (state == WDRC_ST_RUN) & tick & at_top(count) & WDOG_PRESENT
        & ~init_req & ~clr_req;
    assign fire_done = (state == WDRC_ST_FIRE) && (pulse_cnt == 8'h0);

    // State group
    always_comb begin
        next_state = state;
        case (state)
            WDRC_ST_RUN: begin
                if (overflow) begin
                    next_state = WDRC_ST_FIRE;
                end
            end
            WDRC_ST_FIRE: begin
                if (fire_done) begin
                    next_state = WDRC_ST_RUN;
                end
            end
            default: begin
                next_state = WDRC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= WDRC_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Reset pulse group; length fixed so the core sees a clean level
    always_comb begin
        next_pulse_cnt = pulse_cnt;
        next_wdog_reset = 1'b0;
        case (state)
            WDRC_ST_RUN: begin
                if (overflow) begin
                    next_pulse_cnt = 8'(RESET_PULSE_CYC - 1);
                    next_wdog_reset = 1'b1;
                end
            end
            WDRC_ST_FIRE: begin
                if (fire_done) begin
                    next_wdog_reset = 1'b0;
                end else begin
                    next_pulse_cnt = pulse_cnt - 8'h1;
                    next_wdog_reset = 1'b1;
                end
            end
            default: begin
                next_pulse_cnt = 8'h0;
                next_wdog_reset = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pulse_cnt <= 8'h0;
            wdog_reset <= 1'b0;
        end else begin
            pulse_cnt <= next_pulse_cnt;
            wdog_reset <= next_wdog_reset;
        end
    end

    // Counter group; halt is deliberately not an input here
    always_comb begin
        next_count = count;
        case (state)
            WDRC_ST_RUN: begin
                if (init_req) begin
                    next_count = WDRC_CNT_RST;
                end else if (clr_req) begin
                    next_count = WDRC_CNT_RST;
                end else if (tick) begin
                    // Wraps to zero on overflow: 8 ticks, 3.5..4 s
                    next_count = step(count);
                end
            end
            WDRC_ST_FIRE: begin
                next_count = WDRC_CNT_RST;
            end
            default: begin
                next_count = WDRC_CNT_RST;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= WDRC_CNT_RST;
        end else begin
            count <= next_count;
        end
    end

    // Read data group; tracks the count in the same cycle it changes
    always_comb begin
        next_rdata = {1'b0, next_count};
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata <= 4'h0;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign io_rdata_o = rdata;
    assign wdog_reset_o = wdog_reset;

    // Halt level kept as a port for the core, unused by design
    assign unused_halt = halt_i;
endmodule // wdrc_watchdog

// [verification/wdrc_watchdog_sva.sv]
`timescale 1ns/1ps
module wdrc_watchdog_sva #(
    parameter bit WDOG_PRESENT = 1'b1,
    parameter int RESET_PULSE_CYC = 4
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic tick_2hz_i,
    input wire logic init_reset_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [3:0] io_wdata_i,
    input wire logic [3:0] io_rdata_o,
    input wire logic wdog_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Five quiet cycles cover the tick synchroniser delay
    sequence s_quiet; (!io_wr_i && !init_reset_i && $stable(tick_2hz_i))[*5]; endsequence
    sequence s_pulse; wdog_reset_o[*4] ##1 !wdog_reset_o; endsequence
    a_bit3_zero: assert property (io_rdata_o[3] == 1'b0) else $error("bit3 high");
    a_clear_zero: assert property (io_wr_i && io_addr_i == 8'h7f && io_wdata_i[3]
        |=> io_rdata_o == 4'h0) else $error("clear missed");
    a_init_zero: assert property (init_reset_i |=> io_rdata_o == 4'h0) else $error("init");
    a_quiet_hold: assert property (s_quiet |=> $stable(io_rdata_o)) else $error("drift");
    a_count_step: assert property ($changed(io_rdata_o) |-> io_rdata_o == 4'h0
        || io_rdata_o == $past(io_rdata_o) + 4'h1) else $error("bad step");
    a_fire_cause: assert property ($rose(wdog_reset_o) |-> io_rdata_o == 4'h0
        && $past(io_rdata_o) == 4'h7) else $error("bad fire");
    a_pulse_len: assert property ($rose(wdog_reset_o) |-> s_pulse) else $error("pulse");
    a_absent_quiet: assert property (!WDOG_PRESENT |-> !wdog_reset_o) else $error("rst");
endmodule // wdrc_watchdog_sva
bind wdrc_watchdog wdrc_watchdog_sva #(.WDOG_PRESENT(WDOG_PRESENT),
    .RESET_PULSE_CYC(RESET_PULSE_CYC)) u_sva (.clk_i(clk_i), .nrst_i(nrst_i),
    .tick_2hz_i(tick_2hz_i), .init_reset_i(init_reset_i), .io_wr_i(io_wr_i),
    .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .wdog_reset_o(wdog_reset_o));

// [verification/wdrc_watchdog_tb_top.sv]
`timescale 1ns/1ps
module wdrc_watchdog_tb_top;
    logic clk_i = 0, nrst_i = 0, tick = 0, halt = 0, ini = 0, wr = 0, rst;
    logic [7:0] adr = 8'h00;
    logic [3:0] wd = 4'h0, rd, rd2;
    logic rst2;
    int n_mismatch = 0, cmp_count = 0;
    always #12.5 clk_i = ~clk_i;
    wdrc_watchdog wdrc_watchdog_i (.clk_i(clk_i), .nrst_i(nrst_i), .tick_2hz_i(tick),
        .halt_i(halt), .init_reset_i(ini), .io_wr_i(wr), .io_addr_i(adr), .io_wdata_i(wd),
        .io_rdata_o(rd), .wdog_reset_o(rst));
    wdrc_watchdog #(.WDOG_PRESENT(1'b0)) wdrc_watchdog_i2 (.clk_i(clk_i), .nrst_i(nrst_i),
        .tick_2hz_i(tick), .halt_i(halt), .init_reset_i(ini), .io_wr_i(wr), .io_addr_i(adr),
        .io_wdata_i(wd), .io_rdata_o(rd2), .wdog_reset_o(rst2));
    task cyc(input int n); repeat (n) @(posedge clk_i); endtask
    task chk(input logic [3:0] e, input logic [3:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    // Fast ticks stand in for the slow timer edge
    task ticks(input int n); repeat (n) begin tick <= 1; cyc(4); tick <= 0; cyc(4); end endtask
    task wri(input logic [7:0] a, input logic [3:0] d);
        adr <= a; wd <= d; wr <= 1; cyc(1); wr <= 0; cyc(1);
    endtask
    task close_out;
        $display("cmp %0d mismatch %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task t_count;
        halt <= 1; ticks(3); chk(4'h3, rd);
        wri(8'h7f, 4'h7); chk(4'h3, rd);
        wri(8'h7e, 4'h8); chk(4'h3, rd);
        wri(8'h7f, 4'h8); chk(4'h0, rd);
        halt <= 0; $display("count done");
    endtask
    task t_race;
        ticks(2); tick <= 1; cyc(2); wri(8'h7f, 4'h8); chk(4'h0, rd);
        tick <= 0; cyc(4); $display("race done");
    endtask
    task t_fire;
        int i;
        ini <= 1; cyc(1); ini <= 0; cyc(1); chk(4'h0, rd);
        ticks(7); chk(4'h7, rd); tick <= 1; i = 0;
        while (rst !== 1'b1 && i < 10) begin cyc(1); i++; end
        chk(4'h1, {3'h0, rst}); chk(4'h0, rd);
        chk(4'h0, {3'h0, rst2}); chk(4'h0, rd2);
        tick <= 0; ini <= 1; cyc(1); ini <= 0; cyc(6); chk(4'h0, rd);
        $display("fire done");
    endtask
    initial begin
        cyc(8); nrst_i <= 1; cyc(1); chk(4'h0, rd);
        t_count; t_race; t_fire; close_out;
    end
endmodule // wdrc_watchdog_tb_top
